// ===== src/dsam_regs.vh
// Purpose: Register map, field positions and timing constants of the alarm monitor
// Assumes: Printed offsets are register indices; byte address is four times the index
// Notes: Included by every design file of the block
`ifndef DSAM_REGS_VH
`define DSAM_REGS_VH

// ==========================================================================
// Register indices and byte address width
// ==========================================================================
`define DSAM_IDX_THR_ONE 8'h40
`define DSAM_IDX_THR_TWO 8'h42
`define DSAM_IDX_SPAN_ONE 8'h44
`define DSAM_IDX_SPAN_TWO 8'h46
`define DSAM_IDX_CTRL 8'h48
`define DSAM_IDX_DIAG 8'h4A
`define DSAM_IDX_IRQ_STAT 8'h4C
`define DSAM_IDX_IRQ_MASK 8'h4E
`define DSAM_ADDR_W 10

// ==========================================================================
// Reset values
// ==========================================================================
`define DSAM_RST_THR 16'h0000
`define DSAM_RST_SPAN 16'h0000
`define DSAM_RST_CTRL 16'h0000
`define DSAM_RST_IRQ 2'h0

// ==========================================================================
// Control and diagnostic field positions
// ==========================================================================
`define DSAM_CTRL_SRC_TWO_HI 15
`define DSAM_CTRL_SRC_TWO_LO 12
`define DSAM_CTRL_SRC_ONE_HI 11
`define DSAM_CTRL_SRC_ONE_LO 8
`define DSAM_CTRL_DYN_TWO 7
`define DSAM_CTRL_DYN_ONE 6
`define DSAM_CTRL_POL_TWO 5
`define DSAM_CTRL_POL_ONE 4
`define DSAM_CTRL_FILT 3
`define DSAM_CTRL_IND_EN 2
`define DSAM_CTRL_IND_POL 1
`define DSAM_CTRL_IND_LINE 0
`define DSAM_DIAG_ALM_ONE 8
`define DSAM_DIAG_ALM_TWO 9

// ==========================================================================
// Source selection codes
// ==========================================================================
`define DSAM_SRC_OFF 4'h0
`define DSAM_SRC_GYRO_X 4'h1
`define DSAM_SRC_MAGNET_X 4'h7
`define DSAM_SRC_MAGNET_Y 4'h9
`define DSAM_SRC_TEMP 4'hC
`define DSAM_NUM_SRC 11

// ==========================================================================
// Sample timing
// ==========================================================================
`define DSAM_SAMPLE_RATE_MSPS 819200
`define DSAM_HIST_DEPTH 256

// ==========================================================================
// Bus responses
// ==========================================================================
`define DSAM_RESP_OKAY 2'h0
`define DSAM_RESP_SLVERR 2'h2

`endif

// ===== src/dsam_hist.v
// Purpose: History of selected samples for the rate-of-change comparison
// Assumes: One push per sample update; span of zero treated as one
// Notes: Read of the word span samples back is combinational
`timescale 1ns/100ps
`include "dsam_regs.vh"

module dsam_hist #(
   parameter W = 16,
   parameter DEPTH = `DSAM_HIST_DEPTH,
   parameter PW = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Control
   input wire flush,
   input wire push,
   input wire [W-1:0] din,
   input wire [PW-1:0] span,
   // Result
   output wire [W-1:0] old_word,
   output wire old_ok
);

   reg [W-1:0] mem [0:DEPTH-1];
   reg [PW-1:0] wptr_reg;
   reg [PW:0] count_reg;
   wire [PW-1:0] span_eff;

   // Zero and one both mean one sample
   assign span_eff = (span == {PW{1'b0}}) ? {{(PW-1){1'b0}}, 1'b1} : span;
   assign old_word = mem[wptr_reg - span_eff];
   assign old_ok = (count_reg >= {1'b0, span_eff});

   always @(posedge aclk) begin
      if (push) begin
         mem[wptr_reg] <= din;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || flush) begin
         wptr_reg <= {PW{1'b0}};
         count_reg <= {(PW+1){1'b0}};
      end else if (push) begin
         wptr_reg <= wptr_reg + {{(PW-1){1'b0}}, 1'b1};
         if (count_reg != DEPTH[PW:0]) begin
            count_reg <= count_reg + {{PW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

// ===== src/dsam_alarm.v
// Purpose: One alarm channel, static or rate-of-change comparison
// Assumes: Static compare is signed; dynamic compares magnitude of the change
// Notes: Result updates only on a sample update, and clears at once while src_ok is low
`timescale 1ns/100ps
`include "dsam_regs.vh"

module dsam_alarm (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Sample update
   input wire sample_stb,
   input wire src_ok,
   input wire [15:0] cur_word,
   input wire [15:0] old_word,
   input wire old_ok,
   // Configuration
   input wire dyn_mode,
   input wire pol_above,
   input wire [15:0] threshold,
   // Result
   output reg alarm_reg
);

   wire signed [16:0] delta;
   wire [16:0] delta_mag;
   wire static_hit;
   wire dyn_hit;

   assign delta = $signed({cur_word[15], cur_word}) - $signed({old_word[15], old_word});
   assign delta_mag = delta[16] ? (~delta + 17'h00001) : delta;
   // Polarity picks above or below
   assign static_hit = pol_above ? ($signed(cur_word) > $signed(threshold)) :
                       ($signed(cur_word) < $signed(threshold));
   assign dyn_hit = old_ok && (pol_above ? (delta_mag > {1'b0, threshold}) :
                    (delta_mag < {1'b0, threshold}));

   always @(posedge aclk) begin
      if (!aresetn) begin
         alarm_reg <= 1'b0;
      end else if (!src_ok) begin
         alarm_reg <= 1'b0;
      end else if (sample_stb) begin
         alarm_reg <= dyn_mode ? dyn_hit : static_hit;
      end
   end

endmodule

// ===== src/dsam_top.v
// Purpose: Dual sensor alarm monitor with AXI4-Lite registers
// Assumes: Sensor words and sample strobe come from logic on aclk
// Notes: Indicator drives one of two digital lines
// What this block does
// - Two independent alarms, own threshold, polarity, source.
// - Static mode compares selected word against threshold.
// - Thresholds are 16 bits, reset to zero.
// - Dynamic mode compares change over span samples.
// - Span low byte; zero and one mean one.
// - Diagnostic flags bits 9:8 show both alarms.
// - Source codes select gyro, accel, magnet, pressure, temperature.
// - Control top nibble alarm two, next alarm one.
// - Bits 7 and 6 choose dynamic or static.
// - Bits 5 and 4 choose above or below.
// - Bit 3 selects filtered or unfiltered data.
// - Bit 2 enables the hardware indicator.
// - Bit 1 sets indicator active level.
// - Bit 0 routes indicator to second line.
// - Spans count internal samples at 819.2 per second.
`timescale 1ns/100ps
`include "dsam_regs.vh"

module dsam_top #(
   parameter NSRC = `DSAM_NUM_SRC,
   parameter DEPTH = `DSAM_HIST_DEPTH
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [`DSAM_ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [`DSAM_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // Sensor datapath, word k at bits 16k+15:16k
   input wire sample_stb,
   input wire [NSRC*16-1:0] sensor_raw,
   input wire [NSRC*16-1:0] sensor_filt,
   // Indicator lines
   output reg io_line_first_out,
   output reg io_line_first_oe_n,
   output reg io_line_second_out,
   output reg io_line_second_oe_n,
   // Interrupt
   output wire irq
);

   // ======================================================================
   // Register storage
   // ======================================================================
   reg [15:0] thr_one_reg;
   reg [15:0] thr_two_reg;
   reg [15:0] span_one_reg;
   reg [15:0] span_two_reg;
   reg [15:0] ctrl_reg;
   reg [1:0] irq_stat_reg;
   reg [1:0] irq_mask_reg;
   reg [1:0] alarm_prev_reg;

   // ======================================================================
   // Bus slave state
   // ======================================================================
   reg aw_held_reg;
   reg w_held_reg;
   reg [`DSAM_ADDR_W-1:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;

   wire do_write;
   wire [7:0] wr_idx;
   wire [7:0] rd_idx;
   wire wr_ok;
   wire wr_thr_one;
   wire wr_thr_two;
   wire wr_span_one;
   wire wr_span_two;
   wire wr_ctrl;
   wire wr_stat;
   wire wr_mask;
   wire alarm_one;
   wire alarm_two;
   wire [1:0] alarm_rise;
   wire [1:0] irq_stat_next;

   // ======================================================================
   // Helpers
   // ======================================================================
   function [15:0] merge16;
      input [15:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      begin
         merge16[7:0] = strb[0] ? new_val[7:0] : old_val[7:0];
         merge16[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
      end
   endfunction

   // Map source code to word index, bit 4 marks a valid source
   function [4:0] src_index;
      input [3:0] code;
      begin
         if (code >= `DSAM_SRC_GYRO_X && code <= `DSAM_SRC_MAGNET_X) begin
            src_index = {1'b1, code - 4'h1};
         end else if (code >= `DSAM_SRC_MAGNET_Y && code <= `DSAM_SRC_TEMP) begin
            src_index = {1'b1, code - 4'h2};
         end else begin
            src_index = 5'h00;
         end
      end
   endfunction

   function reg_mapped;
      input [7:0] idx;
      begin
         case (idx)
            `DSAM_IDX_THR_ONE, `DSAM_IDX_THR_TWO, `DSAM_IDX_SPAN_ONE,
            `DSAM_IDX_SPAN_TWO, `DSAM_IDX_CTRL, `DSAM_IDX_DIAG,
            `DSAM_IDX_IRQ_STAT, `DSAM_IDX_IRQ_MASK: begin
               reg_mapped = 1'b1;
            end
            default: begin
               reg_mapped = 1'b0;
            end
         endcase
      end
   endfunction

   // ======================================================================
   // Write channel
   // ======================================================================
   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
   assign wr_idx = awaddr_reg[9:2];
   assign wr_ok = reg_mapped(wr_idx) && (wr_idx != `DSAM_IDX_DIAG);
   assign wr_thr_one = do_write && (wr_idx == `DSAM_IDX_THR_ONE);
   assign wr_thr_two = do_write && (wr_idx == `DSAM_IDX_THR_TWO);
   assign wr_span_one = do_write && (wr_idx == `DSAM_IDX_SPAN_ONE);
   assign wr_span_two = do_write && (wr_idx == `DSAM_IDX_SPAN_TWO);
   assign wr_ctrl = do_write && (wr_idx == `DSAM_IDX_CTRL);
   assign wr_stat = do_write && (wr_idx == `DSAM_IDX_IRQ_STAT);
   assign wr_mask = do_write && (wr_idx == `DSAM_IDX_IRQ_MASK);

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= {`DSAM_ADDR_W{1'b0}};
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `DSAM_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? `DSAM_RESP_OKAY : `DSAM_RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Configuration registers
   // ======================================================================
   always @(posedge aclk) begin
      if (!aresetn) begin
         thr_one_reg <= `DSAM_RST_THR;
         thr_two_reg <= `DSAM_RST_THR;
         span_one_reg <= `DSAM_RST_SPAN;
         span_two_reg <= `DSAM_RST_SPAN;
         ctrl_reg <= `DSAM_RST_CTRL;
         irq_mask_reg <= `DSAM_RST_IRQ;
      end else begin
         if (wr_thr_one) begin
            thr_one_reg <= merge16(thr_one_reg, wdata_reg, wstrb_reg);
         end
         if (wr_thr_two) begin
            thr_two_reg <= merge16(thr_two_reg, wdata_reg, wstrb_reg);
         end
         if (wr_span_one) begin
            span_one_reg <= merge16(span_one_reg, wdata_reg, wstrb_reg);
         end
         if (wr_span_two) begin
            span_two_reg <= merge16(span_two_reg, wdata_reg, wstrb_reg);
         end
         if (wr_ctrl) begin
            ctrl_reg <= merge16(ctrl_reg, wdata_reg, wstrb_reg);
         end
         if (wr_mask && wstrb_reg[0]) begin
            irq_mask_reg <= wdata_reg[1:0];
         end
      end
   end

   // ======================================================================
   // Source selection
   // ======================================================================
   wire [3:0] src_one_code;
   wire [3:0] src_two_code;
   wire [4:0] src_one_idx;
   wire [4:0] src_two_idx;
   wire use_filt;
   wire [NSRC*16-1:0] sensor_sel;
   wire [15:0] cur_one;
   wire [15:0] cur_two;
   wire [15:0] old_one;
   wire [15:0] old_two;
   wire old_one_ok;
   wire old_two_ok;
   wire flush_one;
   wire flush_two;

   assign src_one_code = ctrl_reg[`DSAM_CTRL_SRC_ONE_HI:`DSAM_CTRL_SRC_ONE_LO];
   assign src_two_code = ctrl_reg[`DSAM_CTRL_SRC_TWO_HI:`DSAM_CTRL_SRC_TWO_LO];
   assign src_one_idx = src_index(src_one_code);
   assign src_two_idx = src_index(src_two_code);
   assign use_filt = ctrl_reg[`DSAM_CTRL_FILT];
   assign sensor_sel = use_filt ? sensor_filt : sensor_raw;
   assign cur_one = sensor_sel[src_one_idx[3:0]*16 +: 16];
   assign cur_two = sensor_sel[src_two_idx[3:0]*16 +: 16];
   // New source or span restarts the history
   assign flush_one = wr_ctrl || wr_span_one;
   assign flush_two = wr_ctrl || wr_span_two;

   // ======================================================================
   // Alarm channels
   // ======================================================================
   // History depth covers the longest span, counted in sample updates
   dsam_hist #(
      .W(16),
      .DEPTH(DEPTH),
      .PW(8)
   ) u_hist_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .flush(flush_one),
      .push(sample_stb && src_one_idx[4]),
      .din(cur_one),
      .span(span_one_reg[7:0]),
      .old_word(old_one),
      .old_ok(old_one_ok)
   );

   dsam_hist #(
      .W(16),
      .DEPTH(DEPTH),
      .PW(8)
   ) u_hist_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .flush(flush_two),
      .push(sample_stb && src_two_idx[4]),
      .din(cur_two),
      .span(span_two_reg[7:0]),
      .old_word(old_two),
      .old_ok(old_two_ok)
   );

   // Each channel has its own threshold, polarity and source
   dsam_alarm u_alarm_one (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_stb(sample_stb),
      .src_ok(src_one_idx[4]),
      .cur_word(cur_one),
      .old_word(old_one),
      .old_ok(old_one_ok),
      .dyn_mode(ctrl_reg[`DSAM_CTRL_DYN_ONE]),
      .pol_above(ctrl_reg[`DSAM_CTRL_POL_ONE]),
      .threshold(thr_one_reg),
      .alarm_reg(alarm_one)
   );

   dsam_alarm u_alarm_two (
      .aclk(aclk),
      .aresetn(aresetn),
      .sample_stb(sample_stb),
      .src_ok(src_two_idx[4]),
      .cur_word(cur_two),
      .old_word(old_two),
      .old_ok(old_two_ok),
      .dyn_mode(ctrl_reg[`DSAM_CTRL_DYN_TWO]),
      .pol_above(ctrl_reg[`DSAM_CTRL_POL_TWO]),
      .threshold(thr_two_reg),
      .alarm_reg(alarm_two)
   );

   // ======================================================================
   // Interrupt status, set wins over clear
   // ======================================================================
   assign alarm_rise = {alarm_two, alarm_one} & ~alarm_prev_reg;
   assign irq_stat_next = (irq_stat_reg &
                          ~((wr_stat && wstrb_reg[0]) ? wdata_reg[1:0] : 2'h0)) | alarm_rise;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= `DSAM_RST_IRQ;
         alarm_prev_reg <= 2'h0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         alarm_prev_reg <= {alarm_two, alarm_one};
      end
   end

   // ======================================================================
   // Hardware indicator
   // ======================================================================
   wire ind_active;
   wire ind_level;
   wire ind_en;

   assign ind_en = ctrl_reg[`DSAM_CTRL_IND_EN];
   assign ind_active = alarm_one || alarm_two;
   assign ind_level = ctrl_reg[`DSAM_CTRL_IND_POL] ? ind_active : !ind_active;

   always @(posedge aclk) begin
      if (!aresetn) begin
         io_line_first_out <= 1'b0;
         io_line_first_oe_n <= 1'b1;
         io_line_second_out <= 1'b0;
         io_line_second_oe_n <= 1'b1;
      end else begin
         io_line_first_out <= ind_level;
         io_line_second_out <= ind_level;
         io_line_first_oe_n <= !(ind_en && !ctrl_reg[`DSAM_CTRL_IND_LINE]);
         io_line_second_oe_n <= !(ind_en && ctrl_reg[`DSAM_CTRL_IND_LINE]);
      end
   end

   // ======================================================================
   // Read channel
   // ======================================================================
   reg [31:0] rd_mux;

   assign rd_idx = s_axi_araddr[9:2];
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   always @* begin
      rd_mux = 32'h00000000;
      case (rd_idx)
         `DSAM_IDX_THR_ONE: begin
            rd_mux[15:0] = thr_one_reg;
         end
         `DSAM_IDX_THR_TWO: begin
            rd_mux[15:0] = thr_two_reg;
         end
         `DSAM_IDX_SPAN_ONE: begin
            rd_mux[15:0] = span_one_reg;
         end
         `DSAM_IDX_SPAN_TWO: begin
            rd_mux[15:0] = span_two_reg;
         end
         `DSAM_IDX_CTRL: begin
            rd_mux[15:0] = ctrl_reg;
         end
         `DSAM_IDX_DIAG: begin
            rd_mux[`DSAM_DIAG_ALM_ONE] = alarm_one;
            rd_mux[`DSAM_DIAG_ALM_TWO] = alarm_two;
         end
         `DSAM_IDX_IRQ_STAT: begin
            rd_mux[1:0] = irq_stat_reg;
         end
         `DSAM_IDX_IRQ_MASK: begin
            rd_mux[1:0] = irq_mask_reg;
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `DSAM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= reg_mapped(rd_idx) ? `DSAM_RESP_OKAY : `DSAM_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule

// ===== test/dsam_checker_assertions.sv
// Purpose: Bus and indicator checks on dsam_top ports
// Assumes: One clock aclk, synchronous reset aresetn
// Notes: Bound to every dsam_top instance
`timescale 1ns/100ps
// ====================
// Checker
module dsam_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Indicator enables
   input wire logic io_line_first_oe_n,
   input wire logic io_line_second_oe_n
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_wans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wans: assert property (p_wans) else $error("write answer late");
   property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
   property p_bbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
   property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   property p_oneline; io_line_first_oe_n || io_line_second_oe_n; endproperty
   a_oneline: assert property (p_oneline) else $error("both lines driven");
   c_rd: cover property (s_axi_rvalid && s_axi_rready);
   c_wr: cover property (s_axi_bvalid && s_axi_bready);
   c_ind: cover property (!io_line_second_oe_n);
endmodule

bind dsam_top dsam_checker chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .io_line_first_oe_n(io_line_first_oe_n), .io_line_second_oe_n(io_line_second_oe_n));

// ===== test/dsam_sensor_model.sv
// Purpose: Sensor datapath model, words and sample strobes
// Assumes: Sample period shortened to a few clocks
// Notes: Raw and filtered words set independently
`timescale 1ns/100ps
// ====================
// Model
module dsam_sensor_model (
   // Clock
   input wire logic aclk,
   // Sensor words
   output logic sample_stb,
   output logic [175:0] sensor_raw,
   output logic [175:0] sensor_filt
);
   initial begin
      sample_stb = 1'h0;
      sensor_raw = '0;
      sensor_filt = '0;
   end
   task put(input int k, input logic [15:0] r, input logic [15:0] f);
      sensor_raw[16*k+:16] <= r;
      sensor_filt[16*k+:16] <= f;
   endtask
   task fill(input int k, input logic [15:0] v, input logic [15:0] o);
      for (int j = 0; j < 11; j++) put(j, (j == k) ? v : o, 16'h0000);
   endtask
   // One pulse per shortened sample period
   task strobe;
      @(posedge aclk);
      sample_stb <= 1'h1;
      @(posedge aclk);
      sample_stb <= 1'h0;
      repeat (2) @(posedge aclk);
   endtask
endmodule

// ===== test/test_dsam_top.sv
// Purpose: Register and alarm tests of dsam_top
// Assumes: Sensor model drives words and strobes
// Notes: Bus tasks wait for the answer; only the watchdog ends a hang
`timescale 1ns/100ps
module test_dsam_top;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [9:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h3;
   logic [3:0] code;
   wire awready, wready, bvalid, arready, rvalid, irq, stb, o1, e1, o2, e2;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [175:0] raw, filt;
   int fails = 0, cmp_count = 0, i;

   dsam_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_stb(stb),
      .sensor_raw(raw), .sensor_filt(filt), .io_line_first_out(o1), .io_line_first_oe_n(e1),
      .io_line_second_out(o2), .io_line_second_oe_n(e2), .irq(irq));
   dsam_sensor_model pm (.aclk(aclk), .sample_stb(stb), .sensor_raw(raw), .sensor_filt(filt));

   initial begin
      forever #5 aclk = ~aclk;
   end
   // ====================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task wrap_up;
      $display("fails %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ====================
   // Tests
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      for (i = 0; i < 5; i++) rd(10'h100 + 10'(8 * i), 32'h0, 2'h0);
      rd(10'h3FC, 32'h0, 2'h2);
      wr(10'h128, 16'h0001, 2'h2);
      for (i = 0; i < 12; i++) begin
         code = 4'((i < 6) ? i + 1 : (i == 6) ? 7 : (i < 11) ? i + 2 : 0);
         wr(10'h120, {4'h0, code, 8'h10}, 2'h0);
         pm.fill(i % 11, 16'h0100, 16'hFF00);
         pm.strobe();
         rd(10'h128, (code != 4'h0) ? 32'h100 : 32'h0, 2'h0);
      end
      wr(10'h100, 16'h0348, 2'h0);
      wr(10'h120, 16'h060F, 2'h0);
      pm.put(5, 16'h7000, 16'h0100);
      pm.strobe();
      rd(10'h128, 32'h100, 2'h0);
      chk({29'h0, e1, e2, o2}, 32'h5);
      pm.put(5, 16'h0100, 16'h0400);
      pm.strobe();
      rd(10'h128, 32'h0, 2'h0);
      wr(10'h120, 16'h060C, 2'h0);
      // Indicator pins register one edge after the control write
      @(negedge aclk);
      chk({29'h0, e1, e2, o1}, 32'h3);
      wr(10'h120, 16'h0608, 2'h0);
      @(negedge aclk);
      chk({30'h0, e1, e2}, 32'h3);
      wr(10'h130, 16'h0003, 2'h0);
      rd(10'h130, 32'h0, 2'h0);
      wr(10'h108, 16'h000A, 2'h0);
      wr(10'h118, 16'h0002, 2'h0);
      wr(10'h120, 16'h30A0, 2'h0);
      for (i = 0; i < 5; i++) begin
         pm.put(2, (i < 2) ? 16'h0000 : (i < 4) ? 16'h0032 : 16'h0037, 16'h0000);
         pm.strobe();
         rd(10'h128, (i == 2 || i == 3) ? 32'h200 : 32'h0, 2'h0);
      end
      rd(10'h130, 32'h2, 2'h0);
      chk({31'h0, irq}, 32'h0);
      wr(10'h138, 16'h0002, 2'h0);
      chk({31'h0, irq}, 32'h1);
      wr(10'h130, 16'h0002, 2'h0);
      chk({31'h0, irq}, 32'h0);
      rd(10'h130, 32'h0, 2'h0);
      wrap_up;
   end
   initial begin
      #100000;
      fails++;
      wrap_up;
   end
endmodule
